// ==== logic/ext_bus_cs_timing.sv ====
// external memory bus controller: region decode, chip-select timing, register slave
//
// Summary of operation
// - chip-select recovery from bits 31-30: none, 1, 2 or 4 cycles
// - write recovery from bits 29-27: 0 to 6 cycles, code 7 gives 8
// - read recovery from bits 26-24, same coding as write recovery
// - multiplexed bus adds latch wait from bits 21-20: 0, 1, 2 or 4
// - write setup before write strobe from bits 19-18: 0, 1, 2 or 4
// - read setup before read strobe from bits 17-16: 0, 1, 2 or 4
// - strobe carries binary count of internal waits from bits 12-8
// - bits 2-1 pick 8-bit (00) or 16-bit (01) data bus; others forbidden
// - region chip select asserts only when its enable bit 0 is one
// - global multiplier scales setup, wait and recovery by 1, 2 or 4
// - mode bit picks multiplexed (0) or separate (1) bus; stable during access
// - regions decode address 23:16 by base and size; region 0 wins overlap
// - access outside external window faults and runs no external cycle
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module ext_bus_cs_timing (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire ext_bus_pkg::access_t acc_i,
	output logic acc_ack_o,
	output logic acc_fault_o,
	output logic [15:0] acc_rdata_o,
	output logic [23:0] ext_addr_o,
	output logic [15:0] ext_ad_o,
	output logic ext_ad_oe_o,
	input wire logic [15:0] ext_ad_i,
	output logic ext_ale_o,
	output logic ext_rd_n_o,
	output logic ext_wr_n_o,
	output logic [ext_bus_pkg::REGIONS-1:0] region_select_n_o
);

	ext_bus_pkg::state_t s_ff;
	ext_bus_pkg::state_t nxt_s;
	logic [ext_bus_pkg::REGIONS-1:0] hit;

	// ----------------------------------------------------------------
	// cycle-count decoding
	// ----------------------------------------------------------------
	function automatic logic [6:0] dec2(input logic [1:0] code);
		return (code == 2'h3) ? 7'h04 : {5'h00, code};
	endfunction

	function automatic logic [6:0] dec3(input logic [2:0] code);
		return (code == 3'h7) ? 7'h08 : {4'h0, code};
	endfunction

	// code 11 is forbidden; it is treated as quadruple
	function automatic logic [6:0] scale(input logic [6:0] n, input logic [1:0] m);
		return m[1] ? 7'(n << 2) : (m[0] ? 7'(n << 1) : n);
	endfunction

	// zero-length phases are skipped, so a chain of "none" settings costs no cycle
	function automatic logic [13:0] enter_csrec(input ext_bus_pkg::cs_ctrl_t c, input logic [1:0] m);
		logic [6:0] n;
		n = scale(dec2(c.select_recovery_cycles), m);
		return (n != 7'h00) ? {ext_bus_pkg::PH_CSREC, 7'(n - 7'h01)} : {ext_bus_pkg::PH_DONE, 7'h00};
	endfunction

	function automatic logic [13:0] enter_recov(input ext_bus_pkg::cs_ctrl_t c, input logic we,
			input logic [1:0] m);
		logic [6:0] n;
		n = scale(we ? dec3(c.write_recovery_cycles) : dec3(c.read_recovery_cycles), m);
		return (n != 7'h00) ? {ext_bus_pkg::PH_RECOV, 7'(n - 7'h01)} : enter_csrec(c, m);
	endfunction

	function automatic logic [13:0] enter_setup(input ext_bus_pkg::cs_ctrl_t c, input logic we,
			input logic [1:0] m);
		logic [6:0] n;
		n = scale(we ? dec2(c.write_setup_cycles) : dec2(c.read_setup_cycles), m);
		return (n != 7'h00) ? {ext_bus_pkg::PH_SETUP, 7'(n - 7'h01)}
			: {ext_bus_pkg::PH_STROBE, scale({2'h0, c.inserted_wait_states}, m)};
	endfunction

	// ----------------------------------------------------------------
	// region decode
	// ----------------------------------------------------------------
	for (genvar g = 0; g < ext_bus_pkg::REGIONS; g++) begin : g_hit
		assign hit[g] = s_ff.ctrl[g].region_enable &&
			(((acc_i.addr[23:16] ^ s_ff.area[g].region_base)
			& ~(8'hFF >> s_ff.area[g].region_size)) == 8'h00);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		ext_bus_pkg::cs_ctrl_t c;
		logic [31:0] wm;
		logic [31:0] rdv;
		logic [ext_bus_pkg::IRQ_W-1:0] clr;
		logic [ext_bus_pkg::IRQ_W-1:0] ev;
		logic [1:0] m;
		logic nsel;
		logic active;
		logic [13:0] nx;
		nxt_s = s_ff;
		active = 1'b0;
		nx = '0;
		wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		rdv = 32'h0000_0000;
		clr = '0;
		ev = '0;
		m = s_ff.mode[ext_bus_pkg::MULT_LSB +: 2];
		nsel = !hit[0];
		c = s_ff.ctrl[s_ff.sel];
		nxt_s.wb_ack = 1'b0;
		nxt_s.acc_ack = 1'b0;
		nxt_s.acc_fault = 1'b0;

		// pin data: three stages, a change is taken once stages two and three agree
		nxt_s.sync = {s_ff.sync[1:0], ext_ad_i};
		if (s_ff.sync[1] == s_ff.sync[2]) begin
			nxt_s.din = s_ff.sync[2];
		end

		// register slave: one wait state, unmapped offsets read zero and ignore writes
		case (wb_adr_i)
			ext_bus_pkg::ADR_MODE: rdv = s_ff.mode;
			ext_bus_pkg::ADR_IRQ_STAT: rdv = 32'(s_ff.irq_stat);
			ext_bus_pkg::ADR_IRQ_MASK: rdv = 32'(s_ff.irq_mask);
			ext_bus_pkg::ADR_STATE: rdv = 32'(s_ff.phase);
			default: rdv = 32'h0000_0000;
		endcase
		for (int i = 0; i < ext_bus_pkg::REGIONS; i++) begin
			if (wb_adr_i == 8'(int'(ext_bus_pkg::ADR_AREA0) + i * int'(ext_bus_pkg::REGION_STRIDE))) begin
				rdv = s_ff.area[i] & ext_bus_pkg::AREA_WMASK;
			end
			if (wb_adr_i == 8'(int'(ext_bus_pkg::ADR_CTRL0) + i * int'(ext_bus_pkg::REGION_STRIDE))) begin
				rdv = s_ff.ctrl[i] & ext_bus_pkg::CTRL_WMASK;
			end
		end
		if (wb_cyc_i && wb_stb_i && !s_ff.wb_ack) begin
			nxt_s.wb_ack = 1'b1;
			nxt_s.wb_dat = rdv;
			if (wb_we_i) begin
				case (wb_adr_i)
					ext_bus_pkg::ADR_MODE: begin
						// software must not flip the mode mid-access; the access latches only the bus-mode bit, the multiplier is read live
						nxt_s.mode = (s_ff.mode & ~(wm & ext_bus_pkg::MODE_WMASK))
							| (wb_dat_i & wm & ext_bus_pkg::MODE_WMASK);
					end
					ext_bus_pkg::ADR_IRQ_STAT: clr = wb_dat_i[ext_bus_pkg::IRQ_W-1:0] & wm[ext_bus_pkg::IRQ_W-1:0];
					ext_bus_pkg::ADR_IRQ_MASK: begin
						nxt_s.irq_mask = (s_ff.irq_mask & ~wm[ext_bus_pkg::IRQ_W-1:0])
							| (wb_dat_i[ext_bus_pkg::IRQ_W-1:0] & wm[ext_bus_pkg::IRQ_W-1:0]);
					end
					default: begin
					end
				endcase
				for (int i = 0; i < ext_bus_pkg::REGIONS; i++) begin
					if (wb_adr_i == 8'(int'(ext_bus_pkg::ADR_AREA0) + i * int'(ext_bus_pkg::REGION_STRIDE))) begin
						nxt_s.area[i] = (s_ff.area[i] & ~(wm & ext_bus_pkg::AREA_WMASK))
							| (wb_dat_i & wm & ext_bus_pkg::AREA_WMASK);
					end
					if (wb_adr_i == 8'(int'(ext_bus_pkg::ADR_CTRL0) + i * int'(ext_bus_pkg::REGION_STRIDE))) begin
						nxt_s.ctrl[i] = (s_ff.ctrl[i] & ~(wm & ext_bus_pkg::CTRL_WMASK))
							| (wb_dat_i & wm & ext_bus_pkg::CTRL_WMASK);
					end
				end
			end
		end

		// access sequencer
		case (s_ff.phase)
			ext_bus_pkg::PH_IDLE: begin
				if (acc_i.valid && !s_ff.acc_ack && !s_ff.acc_fault) begin
					if (acc_i.addr[31:25] != ext_bus_pkg::EXT_WINDOW_TAG || hit == '0) begin
						nxt_s.acc_fault = 1'b1;
						ev[ext_bus_pkg::IRQ_FAULT] = 1'b1;
					end else begin
						nxt_s.sel = nsel;
						nxt_s.we = acc_i.we;
						nxt_s.addr = acc_i.addr[23:0];
						nxt_s.wdata = acc_i.wdata;
						nxt_s.mux = !s_ff.mode[ext_bus_pkg::MODE_SEPARATE_BIT];
						if (nxt_s.mux) begin
							nxt_s.phase = ext_bus_pkg::PH_ALE;
							nxt_s.cnt = scale(dec2(s_ff.ctrl[nsel].latch_wait_cycles), m);
						end else begin
							nx = enter_setup(s_ff.ctrl[nsel], acc_i.we, m);
							nxt_s.phase = ext_bus_pkg::phase_t'(nx[13:7]);
							nxt_s.cnt = nx[6:0];
						end
					end
				end
			end
			ext_bus_pkg::PH_ALE: begin
				if (s_ff.cnt != 7'h00) begin
					nxt_s.cnt = 7'(s_ff.cnt - 7'h01);
				end else begin
					nx = enter_setup(c, s_ff.we, m);
					nxt_s.phase = ext_bus_pkg::phase_t'(nx[13:7]);
					nxt_s.cnt = nx[6:0];
				end
			end
			ext_bus_pkg::PH_SETUP: begin
				if (s_ff.cnt != 7'h00) begin
					nxt_s.cnt = 7'(s_ff.cnt - 7'h01);
				end else begin
					nxt_s.phase = ext_bus_pkg::PH_STROBE;
					nxt_s.cnt = scale({2'h0, c.inserted_wait_states}, m);
				end
			end
			ext_bus_pkg::PH_STROBE: begin
				if (s_ff.cnt != 7'h00) begin
					nxt_s.cnt = 7'(s_ff.cnt - 7'h01);
				end else begin
					// read data is the filtered pin value, about four cycles old
					nxt_s.acc_rdata = (c.bus_width_select == ext_bus_pkg::WIDTH_8)
						? {8'h00, s_ff.din[7:0]} : s_ff.din;
					nx = enter_recov(c, s_ff.we, m);
					nxt_s.phase = ext_bus_pkg::phase_t'(nx[13:7]);
					nxt_s.cnt = nx[6:0];
				end
			end
			ext_bus_pkg::PH_RECOV: begin
				if (s_ff.cnt != 7'h00) begin
					nxt_s.cnt = 7'(s_ff.cnt - 7'h01);
				end else begin
					nx = enter_csrec(c, m);
					nxt_s.phase = ext_bus_pkg::phase_t'(nx[13:7]);
					nxt_s.cnt = nx[6:0];
				end
			end
			ext_bus_pkg::PH_CSREC: begin
				if (s_ff.cnt != 7'h00) begin
					nxt_s.cnt = 7'(s_ff.cnt - 7'h01);
				end else begin
					nxt_s.phase = ext_bus_pkg::PH_DONE;
				end
			end
			ext_bus_pkg::PH_DONE: begin
				nxt_s.acc_ack = 1'b1;
				ev[ext_bus_pkg::IRQ_DONE] = 1'b1;
				nxt_s.phase = ext_bus_pkg::PH_IDLE;
			end
			default: begin
				nxt_s.phase = ext_bus_pkg::PH_IDLE;
			end
		endcase

		// pins follow the next phase so that every pin leaves a flip-flop
		active = (nxt_s.phase == ext_bus_pkg::PH_ALE) || (nxt_s.phase == ext_bus_pkg::PH_SETUP)
			|| (nxt_s.phase == ext_bus_pkg::PH_STROBE) || (nxt_s.phase == ext_bus_pkg::PH_RECOV);
		nxt_s.cs_n = active ? ~(2'b01 << nxt_s.sel) : 2'b11;
		nxt_s.ale = (nxt_s.phase == ext_bus_pkg::PH_ALE);
		nxt_s.rd_n = !((nxt_s.phase == ext_bus_pkg::PH_STROBE) && !nxt_s.we);
		nxt_s.wr_n = !((nxt_s.phase == ext_bus_pkg::PH_STROBE) && nxt_s.we);
		nxt_s.ad_oe = nxt_s.ale || (active && nxt_s.we);
		if (nxt_s.ale) begin
			nxt_s.ad = nxt_s.addr[15:0];
		end else if (s_ff.ctrl[nxt_s.sel].bus_width_select == ext_bus_pkg::WIDTH_8) begin
			nxt_s.ad = {8'h00, nxt_s.wdata[7:0]};
		end else begin
			nxt_s.ad = nxt_s.wdata;
		end
		nxt_s.slen = (nxt_s.phase == ext_bus_pkg::PH_STROBE) ? 7'(s_ff.slen + 7'h01) : 7'h00;

		// a new event beats a clear in the same cycle
		nxt_s.irq_stat = (s_ff.irq_stat & ~clr) | ev;
		nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff <= '0;
			s_ff.phase <= ext_bus_pkg::PH_IDLE;
			s_ff.mode <= ext_bus_pkg::MODE_RESET;
			s_ff.area <= {ext_bus_pkg::REGIONS{ext_bus_pkg::AREA_RESET}};
			s_ff.ctrl <= {ext_bus_pkg::REGIONS{ext_bus_pkg::CTRL_RESET}};
			s_ff.cs_n <= 2'b11;
			s_ff.rd_n <= 1'b1;
			s_ff.wr_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign wb_dat_o = s_ff.wb_dat;
	assign wb_ack_o = s_ff.wb_ack;
	assign irq_o = s_ff.irq;
	assign acc_ack_o = s_ff.acc_ack;
	assign acc_fault_o = s_ff.acc_fault;
	assign acc_rdata_o = s_ff.acc_rdata;
	assign ext_addr_o = s_ff.addr;
	assign ext_ad_o = s_ff.ad;
	assign ext_ad_oe_o = s_ff.ad_oe;
	assign ext_ale_o = s_ff.ale;
	assign ext_rd_n_o = s_ff.rd_n;
	assign ext_wr_n_o = s_ff.wr_n;
	assign region_select_n_o = s_ff.cs_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_fault_no_cycle: assert property (acc_fault_o |-> region_select_n_o == 2'b11 && ext_rd_n_o && ext_wr_n_o)
		else $error("faulted access drove an external cycle");
	a_select_enabled: assert property (!region_select_n_o[0] |-> s_ff.ctrl[0].region_enable
		|| $past(s_ff.ctrl[0].region_enable))
		else $error("disabled region selected");
	a_single_select: assert property (region_select_n_o != 2'b00)
		else $error("two regions selected at once");
	a_overlap_region0: assert property (s_ff.phase == ext_bus_pkg::PH_IDLE && acc_i.valid && hit == 2'b11
		&& !acc_fault_o && !acc_ack_o && acc_i.addr[31:25] == ext_bus_pkg::EXT_WINDOW_TAG
		|=> !s_ff.sel)
		else $error("overlap did not pick region 0");
	a_reserved_zero: assert property (wb_ack_o && $past(!wb_we_i) && $past(wb_adr_i) == ext_bus_pkg::ADR_CTRL0
		|-> (wb_dat_o & ~ext_bus_pkg::CTRL_WMASK) == 32'h0000_0000)
		else $error("reserved control bits read nonzero");
	a_narrow_data: assert property (ext_ad_oe_o && !ext_ale_o
		&& s_ff.ctrl[s_ff.sel].bus_width_select == ext_bus_pkg::WIDTH_8 |-> ext_ad_o[15:8] == 8'h00)
		else $error("upper byte driven on 8-bit region");
	a_latch_mux_only: assert property (ext_ale_o |-> s_ff.mux && !region_select_n_o[s_ff.sel])
		else $error("address latch outside multiplexed access");
	a_strobe_length: assert property (s_ff.phase == ext_bus_pkg::PH_STROBE && s_ff.cnt == 7'h00
		|-> s_ff.slen == 7'(scale({2'h0, c_sel().inserted_wait_states}, s_ff.mode[2:1]) + 7'h01))
		else $error("strobe length differs from wait setting");
	a_recovery_cs_held: assert property ($rose(ext_rd_n_o) && c_sel().read_recovery_cycles != 3'h0
		|-> !region_select_n_o[s_ff.sel])
		else $error("select released during read recovery");
	a_write_recovery: assert property ($rose(ext_wr_n_o) && c_sel().write_recovery_cycles == 3'h7
		&& s_ff.mode[2:1] == 2'h0 |-> !region_select_n_o[s_ff.sel] [*8])
		else $error("write recovery shorter than eight cycles");
	a_setup_before: assert property ($fell(ext_wr_n_o) && c_sel().write_setup_cycles != 2'h0
		|-> $past(s_ff.phase == ext_bus_pkg::PH_SETUP))
		else $error("write strobe without setup");
	a_cs_recovery: assert property ($rose(region_select_n_o[s_ff.sel]) && c_sel().select_recovery_cycles != 2'h0
		|-> !acc_ack_o ##1 !acc_ack_o)
		else $error("acknowledge before select recovery");
	a_irq_level: assert property (irq_o == |(s_ff.irq_stat & s_ff.irq_mask))
		else $error("interrupt line disagrees with status");

	function automatic ext_bus_pkg::cs_ctrl_t c_sel();
		return s_ff.ctrl[s_ff.sel];
	endfunction

endmodule // ext_bus_cs_timing

// ==== logic/ext_bus_pkg.sv ====
// package: register map, field layouts, states and carriers of the external bus timing block
package ext_bus_pkg;

	localparam int REGIONS = 2;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_MODE = 8'h00;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADR_STATE = 8'h0C;
	localparam logic [7:0] ADR_AREA0 = 8'h10;
	localparam logic [7:0] ADR_CTRL0 = 8'h18;
	localparam logic [7:0] REGION_STRIDE = 8'h04;

	// ----------------------------------------------------------------
	// reset values and writable bits
	// ----------------------------------------------------------------
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] MODE_WMASK = 32'h0000_0007;
	localparam logic [31:0] AREA_RESET = 32'h0000_0000;
	localparam logic [31:0] AREA_WMASK = 32'hFFFF_00FF;
	localparam logic [31:0] CTRL_RESET = 32'h4915_0200;
	localparam logic [31:0] CTRL_WMASK = 32'hFF3F_1F0F;

	// mode register fields
	localparam int MODE_SEPARATE_BIT = 0;
	localparam int MULT_LSB = 1;

	// interrupt status bits
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAULT = 1;

	// external window: address bits 31:25 must match this tag
	localparam logic [6:0] EXT_WINDOW_TAG = 7'h30;

	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] select_recovery_cycles;
		logic [2:0] write_recovery_cycles;
		logic [2:0] read_recovery_cycles;
		logic [1:0] rsv_a;
		logic [1:0] latch_wait_cycles;
		logic [1:0] write_setup_cycles;
		logic [1:0] read_setup_cycles;
		logic [2:0] rsv_b;
		logic [4:0] inserted_wait_states;
		logic [3:0] rsv_c;
		logic rsv_zero;
		logic [1:0] bus_width_select;
		logic region_enable;
	} cs_ctrl_t;

	typedef struct packed {
		logic [7:0] fixed_top;
		logic [7:0] region_base;
		logic [7:0] rsv;
		logic [7:0] region_size;
	} area_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [31:0] addr;
		logic [15:0] wdata;
	} access_t;

	typedef enum logic [6:0] {
		PH_IDLE = 7'h01,
		PH_ALE = 7'h02,
		PH_SETUP = 7'h04,
		PH_STROBE = 7'h08,
		PH_RECOV = 7'h10,
		PH_CSREC = 7'h20,
		PH_DONE = 7'h40
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [6:0] cnt;
		logic [6:0] slen;
		logic sel;
		logic we;
		logic mux;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [31:0] mode;
		area_t [REGIONS-1:0] area;
		cs_ctrl_t [REGIONS-1:0] ctrl;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic [REGIONS-1:0] cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic [15:0] ad;
		logic ad_oe;
		logic acc_ack;
		logic acc_fault;
		logic [15:0] acc_rdata;
		logic [2:0][15:0] sync;
		logic [15:0] din;
	} state_t;

endpackage

// ==== sim/ext_mem_model.sv ====
// behavioural external sram model on the far side of the chip-select timing block
`timescale 1ns/1ns
module ext_mem_model (
	input wire logic clk_i,
	input wire logic [1:0] select_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic ale_i,
	input wire logic [23:0] addr_i,
	input wire logic [15:0] ad_i,
	input wire logic ad_oe_i,
	output logic [15:0] ad_o,
	output logic [1:0][15:0] sel_count_o,
	output logic [15:0] ale_count_o
);
	logic [15:0] mem [logic [23:0]];
	logic [1:0] sel_q = 2'b11;
	logic ale_q = 1'b0;

	initial begin
		ad_o = 16'h0000;
		sel_count_o = '0;
		ale_count_o = 16'h0000;
	end

	// ----------------------------------------------------------------
	// storage and pin activity counters
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		for (int i = 0; i < 2; i++) begin
			if (sel_q[i] && !select_n_i[i]) begin
				sel_count_o[i] <= sel_count_o[i] + 16'h0001;
			end
		end
		if (ale_i && !ale_q) begin
			ale_count_o <= ale_count_o + 16'h0001;
		end
		sel_q <= select_n_i;
		ale_q <= ale_i;
		if (!wr_n_i && ad_oe_i && select_n_i != 2'b11) begin
			mem[addr_i] = ad_i;
		end
		// a released bus toggles every cycle so stale data never looks valid
		if (!rd_n_i && !ad_oe_i && select_n_i != 2'b11) begin
			ad_o <= mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
		end else begin
			ad_o <= ~ad_o;
		end
	end
endmodule // ext_mem_model

// ==== sim/ext_bus_chip_select_timing_tb.sv ====
// self-checking bench of the chip-select timing block with an sram model
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ext_bus_chip_select_timing_tb;
	localparam logic [7:0] r_mode = ext_bus_pkg::ADR_MODE;
	localparam logic [7:0] r_ctrl0 = ext_bus_pkg::ADR_CTRL0;
	localparam logic [7:0] r_ctrl1 = ext_bus_pkg::ADR_CTRL0 + ext_bus_pkg::REGION_STRIDE;
	localparam logic [7:0] r_area0 = ext_bus_pkg::ADR_AREA0;
	localparam logic [7:0] r_area1 = ext_bus_pkg::ADR_AREA0 + ext_bus_pkg::REGION_STRIDE;
	localparam logic [7:0] r_stat = ext_bus_pkg::ADR_IRQ_STAT;
	// reads need five or more strobe waits: one cycle in the model plus the three-stage pin filter
	localparam logic [31:0] cfg_ctrl [5] = '{32'h0000_0503, 32'hFE0F_0F03, 32'h4F36_0303, 32'h9118_0403,
		32'h0000_0501};
	localparam logic [31:0] cfg_mode [5] = '{32'h1, 32'h1, 32'h2, 32'h4, 32'h0};
	typedef struct {bit chk; logic [31:0] e;} wb_note_t;
	typedef struct {bit fault; bit rd; int lat; logic [15:0] d;} acc_note_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	ext_bus_pkg::access_t acc = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, irq_o, acc_ack_o, acc_fault_o, ext_ad_oe_o, ext_ale_o, ext_rd_n_o, ext_wr_n_o;
	logic [15:0] acc_rdata_o, ext_ad_o, ext_ad_i, ale_count, a0, d;
	logic [23:0] ext_addr_o;
	logic [1:0] region_select_n_o;
	logic [1:0][15:0] sel_count, s0;
	logic [31:0] md;
	ext_bus_pkg::cs_ctrl_t cw;
	int err_count = 0;
	int tests_run = 0;
	int cyc_n = 0;
	int t_take = 0;
	int seed = 68365;
	int kk, base;
	bit vprev = 1'b0;
	wb_note_t wn;
	acc_note_t an;
	wb_note_t wq[$];
	acc_note_t aq[$];

	always #50 clk_i = ~clk_i;

	ext_bus_cs_timing u_ext_bus_cs_timing (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.irq_o(irq_o), .acc_i(acc), .acc_ack_o(acc_ack_o), .acc_fault_o(acc_fault_o), .acc_rdata_o(acc_rdata_o),
		.ext_addr_o(ext_addr_o), .ext_ad_o(ext_ad_o), .ext_ad_oe_o(ext_ad_oe_o), .ext_ad_i(ext_ad_i),
		.ext_ale_o(ext_ale_o), .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o),
		.region_select_n_o(region_select_n_o));
	ext_mem_model u_ext_mem_model (.clk_i(clk_i), .select_n_i(region_select_n_o), .rd_n_i(ext_rd_n_o),
		.wr_n_i(ext_wr_n_o), .ale_i(ext_ale_o), .addr_i(ext_addr_o), .ad_i(ext_ad_o), .ad_oe_i(ext_ad_oe_o),
		.ad_o(ext_ad_i), .sel_count_o(sel_count), .ale_count_o(ale_count));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic int dec2(input logic [1:0] c);
		return (c == 2'h3) ? 4 : int'(c);
	endfunction

	function automatic int dec3(input logic [2:0] c);
		return (c == 3'h7) ? 8 : int'(c);
	endfunction

	task automatic tally_and_finish();
		if (err_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, input bit c, input logic [31:0] e);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		sel <= 4'hF;
		wq.push_back('{c, e});
		do @(negedge clk_i); while (wb_ack_o !== 1'b1);
		@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] v, input bit f, input int lat,
		input logic [15:0] e);
		@(posedge clk_i);
		acc <= '{valid: 1'b1, we: w, addr: a, wdata: v};
		aq.push_back('{f, !w, lat, e});
		do @(negedge clk_i); while (acc_ack_o !== 1'b1 && acc_fault_o !== 1'b1);
		@(posedge clk_i);
		acc.valid <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// monitor: results are matched against the oldest note
	// ----------------------------------------------------------------
	always @(posedge clk_i) cyc_n <= cyc_n + 1;

	always @(negedge clk_i) begin
		if (acc.valid && !vprev) begin
			// latency counts from the edge that raises valid
			t_take = cyc_n;
		end
		vprev = acc.valid;
		if (wb_ack_o === 1'b1) begin
			wn = wq.pop_front();
			if (wn.chk) `CHK(wb_dat_o, wn.e)
		end
		if (acc_ack_o === 1'b1 || acc_fault_o === 1'b1) begin
			an = aq.pop_front();
			`CHK({acc_fault_o, acc_ack_o}, {an.fault, !an.fault})
			if (!an.fault) `CHK(cyc_n - t_take, an.lat)
			if (an.rd && !an.fault) `CHK(acc_rdata_o, an.d)
		end
		// every scenario ends well inside this many cycles
		if (cyc_n >= 5000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, r_ctrl0, 32'h0, 1'b1, ext_bus_pkg::CTRL_RESET);
		wb(1'b0, r_mode, 32'h0, 1'b1, 32'h0000_0000);
		wb(1'b0, ext_bus_pkg::ADR_STATE, 32'h0, 1'b1, 32'h0000_0001);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF, 1'b0, 32'h0);
		wb(1'b0, 8'h40, 32'h0, 1'b1, 32'h0000_0000);
		wb(1'b1, r_ctrl1, 32'hFFFF_FFF3, 1'b0, 32'h0);
		wb(1'b0, r_ctrl1, 32'h0, 1'b1, 32'hFF3F_1F03);
		wb(1'b1, r_area0, 32'h6000_0008, 1'b0, 32'h0);
		wb(1'b0, r_area0, 32'h0, 1'b1, 32'h6000_0008);
		wb(1'b1, r_ctrl1, 32'h0000_0302, 1'b0, 32'h0);
		for (int i = 0; i < 5; i++) begin
			md = cfg_mode[i];
			cw = ext_bus_pkg::cs_ctrl_t'(cfg_ctrl[i]);
			kk = 1 << md[2:1];
			wb(1'b1, r_mode, md, 1'b0, 32'h0);
			wb(1'b1, r_ctrl0, cfg_ctrl[i], 1'b0, 32'h0);
			wb(1'b0, r_ctrl0, 32'h0, 1'b1, cfg_ctrl[i]);
			d = 16'($random(seed));
			a0 = ale_count;
			s0 = sel_count;
			base = (md[0] ? 0 : 1 + dec2(cw.latch_wait_cycles) * kk) + 3 + int'(cw.inserted_wait_states) * kk
				+ dec2(cw.select_recovery_cycles) * kk;
			xfer(1'b1, 32'h6000_0000 + 32'(i * 2), d, 1'b0,
				base + (dec2(cw.write_setup_cycles) + dec3(cw.write_recovery_cycles)) * kk, 16'h0);
			xfer(1'b0, 32'h6000_0000 + 32'(i * 2), 16'h0, 1'b0,
				base + (dec2(cw.read_setup_cycles) + dec3(cw.read_recovery_cycles)) * kk,
				cw.bus_width_select == ext_bus_pkg::WIDTH_8 ? {8'h00, d[7:0]} : d);
			`CHK(ale_count - a0, md[0] ? 16'h0000 : 16'h0002)
			`CHK(sel_count - s0, 32'h0000_0002)
		end
		wb(1'b1, r_mode, 32'h1, 1'b0, 32'h0);
		wb(1'b1, r_ctrl0, 32'h0000_0503, 1'b0, 32'h0);
		wb(1'b1, r_area1, 32'h6001_0008, 1'b0, 32'h0);
		s0 = sel_count;
		xfer(1'b0, 32'h6001_0004, 16'h0, 1'b1, 0, 16'h0);
		`CHK(sel_count - s0, 32'h0000_0000)
		wb(1'b1, r_ctrl1, 32'h0000_0503, 1'b0, 32'h0);
		d = 16'($random(seed));
		xfer(1'b1, 32'h6001_0004, d, 1'b0, 8, 16'h0);
		xfer(1'b0, 32'h6001_0004, 16'h0, 1'b0, 8, d);
		`CHK(sel_count - s0, 32'h0002_0000)
		wb(1'b1, r_area1, 32'h6000_0008, 1'b0, 32'h0);
		s0 = sel_count;
		xfer(1'b1, 32'h6000_0100, d, 1'b0, 8, 16'h0);
		`CHK(sel_count - s0, 32'h0000_0001)
		wb(1'b1, r_area0, 32'h6000_0000, 1'b0, 32'h0);
		s0 = sel_count;
		xfer(1'b1, 32'h61FF_FFFE, ~d, 1'b0, 8, 16'h0);
		xfer(1'b0, 32'h61FF_FFFE, 16'h0, 1'b0, 8, ~d);
		xfer(1'b0, 32'h6200_0000, 16'h0, 1'b1, 0, 16'h0);
		xfer(1'b1, 32'h5FFF_FFFE, d, 1'b1, 0, 16'h0);
		`CHK(sel_count - s0, 32'h0000_0002)
		// interrupt: both events are pending, nothing unmasked yet
		`CHK(irq_o, 1'b0)
		wb(1'b0, r_stat, 32'h0, 1'b1, 32'h0000_0003);
		wb(1'b1, ext_bus_pkg::ADR_IRQ_MASK, 32'h2, 1'b0, 32'h0);
		repeat (2) @(negedge clk_i);
		`CHK(irq_o, 1'b1)
		wb(1'b1, r_stat, 32'h1, 1'b0, 32'h0);
		wb(1'b0, r_stat, 32'h0, 1'b1, 32'h0000_0002);
		wb(1'b1, r_stat, 32'h2, 1'b0, 32'h0);
		repeat (2) @(negedge clk_i);
		`CHK(irq_o, 1'b0)
		wb(1'b0, r_stat, 32'h0, 1'b1, 32'h0000_0000);
		repeat (2) @(posedge clk_i);
		tally_and_finish();
	end
endmodule // ext_bus_chip_select_timing_tb
